// >>> inc/slk_pkg.sv
// constants, register map and carrier types of the serial link sync block
package slk_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [6:0]  ADR_DEVICE_CONTROL   = 7'h04;
   localparam logic [6:0]  ADR_CM_TRIM_A        = 7'h1E;
   localparam logic [6:0]  ADR_TERM_TRIM_A      = 7'h1F;
   localparam logic [6:0]  ADR_CM_TRIM_B        = 7'h3D;
   localparam logic [6:0]  ADR_TERM_TRIM_B      = 7'h3E;
   localparam logic [6:0]  ADR_CONTROL_BIT_SEL  = 7'h64;
   localparam logic [6:0]  ADR_RESTART_DELAY    = 7'h67;
   localparam logic [6:0]  ADR_SYNC_EDGE_SEL    = 7'h74;
   localparam logic [6:0]  ADR_LINK_STATUS      = 7'h75;
   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int          CTL_BW_BIT           = 4;
   localparam int          CTL_LANE_SWING_REDUCE_BIT         = 6;
   localparam int          CTL_TRIGGER_MODE_ENABLE_BIT         = 7;
   localparam int          CTL_AUX_OUTPUT_SWING_BIT         = 8;
   localparam logic [15:0] CTL_RESET            = 16'h0051;
   localparam logic [4:0]  TRIM_RESET           = 5'h10;
   localparam int          RLEN_LSB             = 6;
   localparam logic [15:0] RDLY_RESET           = 16'h0418;
   // ****************************************************************
   // link constants
   // ****************************************************************
   localparam logic [15:0] ALIGN_EVEN           = 16'h00FF;
   localparam logic [15:0] ALIGN_ODD            = 16'hFF00;
   localparam logic [4:0]  SEQ_LAST             = 5'h1F;
   localparam logic [3:0]  FRAME_LAST           = 4'hF;
   localparam logic [16:0] SCR_SEED             = 17'h1FFFF;
   localparam logic [6:0]  TS_SEED              = 7'h7F;
   localparam logic [6:0]  TS_TAPS              = 7'h60;
   localparam logic signed [6:0] DISP_MAX       = 7'sd15;

   typedef enum logic [1:0] {
      PH_ALIGN = 2'b00,
      PH_PRBS  = 2'b01,
      PH_NORM  = 2'b10
   } slk_phase_t;

   typedef struct packed {
      logic        trig;
      logic        sat_b;
      logic [11:0] data_b;
      logic        sat_a;
      logic [11:0] data_a;
   } slk_samp_t;

   typedef struct packed {
      logic signed [6:0] rd;
      logic [15:0]       word;
   } slk_enc_t;
endpackage : slk_pkg

// >>> rtl/slk_top.sv
// sample fifo and serial link sync, control bits and clock outputs
// Behaviour
// - after sync, 32 unscrambled frames alternating 0x00FF and 0xFF00
// - then 32 frames of bare scrambler sequence with clock and disparity bits
// - sync pulse in sync mode resets transmit scrambler
// - select bits choose in-range or parity, timestamp or trigger
// - in-range is 1 unless input saturated
// - parity is xor of the 12 sample bits
// - timestamp is X7+X6+1 Galois sequence per frame, reset by sync
// - trigger bit follows input with sample latency, needs select and mode
// - control bit 7 picks sync mode (0) or trigger mode (1)
// - lane swing reduced when 1, default 1
// - bandwidth nominal when 1, default 1
// - per channel termination trim, reset 0x10
// - per channel common mode trim, 32 codes, reset 0x10
// - sync pulse resets frame timing and starts link sync
// - input captured on rising or falling edge; timing reset on rising
// - sync stops data ready for restart delay, default 16
// - chained sync output is input resampled on the clock
// - slow reference is clock divided by 16, never stopped
// - control bit 8 sets aux output swing, reduced when 0
// - frame clock bit inverts every frame
// - invert 15 bits and set disparity bit when running disparity exceeds 15
// - frames leave least significant bit first
`timescale 1ns/10ps
`default_nettype none

module slk_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : slk_fifo

module slk_top #(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [6:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   // samples in
   input  wire logic        sample_valid,
   output logic             sample_ready,
   input  wire logic [11:0] sample_a,
   input  wire logic        sat_a,
   input  wire logic [11:0] sample_b,
   input  wire logic        sat_b,
   // sync pins
   input  wire logic        sync_trigger_input,
   output logic             chained_sync_output,
   output logic             slow_reference_clock,
   output logic             data_ready,
   // serial lanes
   output logic             lane_a,
   output logic             lane_b,
   // analog settings
   output logic             lane_swing_reduce,
   output logic             bandwidth_select,
   output logic             aux_output_swing,
   output logic [4:0]       termination_trim_a,
   output logic [4:0]       termination_trim_b,
   output logic [4:0]       common_mode_trim_a,
   output logic [4:0]       common_mode_trim_b
);
   import slk_pkg::*;

   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic slk_enc_t frame_enc(input logic [14:0] p, input logic signed [6:0] rd);
      logic [4:0]        ones;
      logic signed [6:0] d0;
      logic signed [6:0] sum;
      slk_enc_t          e;
      ones = '0;
      for (int i = 0; i < 15; i++) begin
         ones = ones + 5'(p[i]);
      end
      d0  = 7'(signed'({2'b00, ones, 1'b0})) - 7'sd16;
      sum = rd + d0;
      if (sum > DISP_MAX || sum < -DISP_MAX) begin
         e.word = {1'b1, ~p};
         e.rd   = rd - d0;
      end else begin
         e.word = {1'b0, p};
         e.rd   = sum;
      end
      return e;
   endfunction : frame_enc

   function automatic logic [13:0] ctrl_payload(input logic [11:0] s, input logic sat,
                                               input logic cb1s, input logic cb2s,
                                               input logic tr, input logic ts, input logic trigger_mode_enable);
      logic f1;
      logic f2;
      f1 = cb1s ? ^s : ~sat;
      f2 = cb2s ? (tr & trigger_mode_enable) : ts;
      return {f2, f1, s};
   endfunction : ctrl_payload

   function automatic logic [16:0] scr_next(input logic [16:0] l);
      logic [16:0] n;
      n[2:0] = l[16:14];
      for (int i = 3; i < 17; i++) begin
         n[i] = l[i-3] ^ l[i];
      end
      return n;
   endfunction : scr_next

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [15:0] ctl_r;
   logic [1:0]  cbsel_r;
   logic [11:0] rdly_r;
   logic        capture_edge_select_r;
   logic [4:0]  tta_r;
   logic [4:0]  ttb_r;
   logic [4:0]  cma_r;
   logic [4:0]  cmb_r;
   logic        trigger_mode_enable;
   slk_phase_t  ph_r;
   logic [4:0]  seq_r;

   assign trigger_mode_enable = ctl_r[CTL_TRIGGER_MODE_ENABLE_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_r   <= CTL_RESET;
         cbsel_r <= 2'h0;
         rdly_r  <= RDLY_RESET[11:0];
         capture_edge_select_r  <= 1'b0;
         tta_r   <= TRIM_RESET;
         ttb_r   <= TRIM_RESET;
         cma_r   <= TRIM_RESET;
         cmb_r   <= TRIM_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADR_DEVICE_CONTROL:  ctl_r   <= reg_wdata;
            ADR_CONTROL_BIT_SEL: cbsel_r <= reg_wdata[1:0];
            ADR_RESTART_DELAY:   rdly_r  <= reg_wdata[11:0];
            ADR_SYNC_EDGE_SEL:   capture_edge_select_r  <= reg_wdata[0];
            ADR_TERM_TRIM_A:     tta_r   <= reg_wdata[4:0];
            ADR_TERM_TRIM_B:     ttb_r   <= reg_wdata[4:0];
            ADR_CM_TRIM_A:       cma_r   <= reg_wdata[4:0];
            ADR_CM_TRIM_B:       cmb_r   <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADR_DEVICE_CONTROL:  reg_rdata <= ctl_r;
            ADR_CONTROL_BIT_SEL: reg_rdata <= {14'h0000, cbsel_r};
            ADR_RESTART_DELAY:   reg_rdata <= {4'h0, rdly_r};
            ADR_SYNC_EDGE_SEL:   reg_rdata <= {15'h0000, capture_edge_select_r};
            ADR_TERM_TRIM_A:     reg_rdata <= {11'h000, tta_r};
            ADR_TERM_TRIM_B:     reg_rdata <= {11'h000, ttb_r};
            ADR_CM_TRIM_A:       reg_rdata <= {11'h000, cma_r};
            ADR_CM_TRIM_B:       reg_rdata <= {11'h000, cmb_r};
            ADR_LINK_STATUS:     reg_rdata <= {9'h000, ph_r, seq_r};
            default:             reg_rdata <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lane_swing_reduce  <= 1'b1;
         bandwidth_select   <= 1'b1;
         aux_output_swing   <= 1'b0;
         termination_trim_a <= TRIM_RESET;
         termination_trim_b <= TRIM_RESET;
         common_mode_trim_a <= TRIM_RESET;
         common_mode_trim_b <= TRIM_RESET;
      end else begin
         lane_swing_reduce  <= ctl_r[CTL_LANE_SWING_REDUCE_BIT];
         bandwidth_select   <= ctl_r[CTL_BW_BIT];
         aux_output_swing   <= ctl_r[CTL_AUX_OUTPUT_SWING_BIT];
         termination_trim_a <= tta_r;
         termination_trim_b <= ttb_r;
         common_mode_trim_a <= cma_r;
         common_mode_trim_b <= cmb_r;
      end
   end

   // ****************************************************************
   // sync input capture and pulse detection
   // ****************************************************************
   logic cap_rise_r;
   logic cap_fall_r;
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic sync_pulse;

   always_ff @(posedge clk) begin
      cap_rise_r <= sync_trigger_input;
   end

   always_ff @(negedge clk) begin
      cap_fall_r <= sync_trigger_input;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         lvl_r <= 1'b0;
      end else begin
         s1_r <= capture_edge_select_r ? cap_fall_r : cap_rise_r;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            lvl_r <= s3_r;
         end
      end
   end

   // timing reset acts on the rising edge, only in sync mode
   assign sync_pulse = (s2_r == s3_r) & s3_r & ~lvl_r & ~trigger_mode_enable;

   always_ff @(posedge clk) begin
      if (rst) begin
         chained_sync_output <= 1'b0;
      end else begin
         chained_sync_output <= lvl_r;
      end
   end

   // ****************************************************************
   // slow reference clock and data ready holdoff
   // ****************************************************************
   logic [3:0] sso_cnt_r;
   logic [5:0] hold_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         sso_cnt_r            <= 4'h0;
         slow_reference_clock <= 1'b0;
      end else begin
         sso_cnt_r            <= sso_cnt_r + 4'h1;
         slow_reference_clock <= sso_cnt_r[3];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_r     <= 6'h00;
         data_ready <= 1'b0;
      end else begin
         if (sync_pulse) begin
            hold_r <= rdly_r[RLEN_LSB +: 6];
         end else if (hold_r != 6'h00) begin
            hold_r <= hold_r - 6'h01;
         end
         data_ready <= ~sync_pulse & (hold_r == 6'h00);
      end
   end

   // ****************************************************************
   // sample fifo
   // ****************************************************************
   slk_samp_t in_samp;
   slk_samp_t out_samp;
   logic      out_valid;
   logic      frame_end;
   logic      pop;

   assign in_samp = '{trig: lvl_r, sat_b: sat_b, data_b: sample_b, sat_a: sat_a, data_a: sample_a};
   assign pop     = frame_end & (ph_r == PH_NORM) & ~sync_pulse;

   slk_fifo #(
      .W ($bits(slk_samp_t)),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (in_samp),
      .out_valid (out_valid),
      .out_ready (pop),
      .out_data  (out_samp)
   );

   // ****************************************************************
   // frame timing, phase, scrambler and timestamp
   // ****************************************************************
   logic [3:0]        fcnt_r;
   logic [16:0]       scr_r;
   logic [6:0]        ts_r;
   logic              clkb_r;
   logic signed [6:0] rda_r;
   logic signed [6:0] rdb_r;
   logic [15:0]       sha_r;
   logic [15:0]       shb_r;
   slk_samp_t         cur;
   slk_enc_t          enc_a;
   slk_enc_t          enc_b;
   logic [13:0]       pay_a;
   logic [13:0]       pay_b;

   assign frame_end = (fcnt_r == FRAME_LAST);
   assign cur       = out_valid ? out_samp : '0;

   always_comb begin
      pay_a = scr_r[13:0];
      pay_b = scr_r[13:0];
      if (ph_r == PH_NORM) begin
         pay_a = scr_r[13:0] ^ ctrl_payload(cur.data_a, cur.sat_a, cbsel_r[0], cbsel_r[1],
                                            cur.trig, ts_r[0], trigger_mode_enable);
         pay_b = scr_r[13:0] ^ ctrl_payload(cur.data_b, cur.sat_b, cbsel_r[0], cbsel_r[1],
                                            cur.trig, ts_r[0], trigger_mode_enable);
      end
      enc_a = frame_enc({clkb_r, pay_a}, rda_r);
      enc_b = frame_enc({clkb_r, pay_b}, rdb_r);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fcnt_r <= 4'h0;
         ph_r   <= PH_NORM;
         seq_r  <= 5'h00;
      end else if (sync_pulse) begin
         fcnt_r <= 4'h0;
         ph_r   <= PH_ALIGN;
         seq_r  <= 5'h00;
      end else begin
         fcnt_r <= fcnt_r + 4'h1;
         if (frame_end) begin
            seq_r <= seq_r + 5'h01;
            unique case (ph_r)
               PH_ALIGN: begin
                  if (seq_r == SEQ_LAST) begin
                     ph_r <= PH_PRBS;
                  end
               end
               PH_PRBS: begin
                  if (seq_r == SEQ_LAST) begin
                     ph_r <= PH_NORM;
                  end
               end
               PH_NORM: begin
                  seq_r <= 5'h00;
               end
               default: ph_r <= PH_NORM;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         scr_r  <= SCR_SEED;
         ts_r   <= TS_SEED;
         clkb_r <= 1'b0;
      end else if (sync_pulse) begin
         scr_r  <= SCR_SEED;
         ts_r   <= TS_SEED;
         clkb_r <= 1'b0;
      end else if (frame_end) begin
         clkb_r <= ~clkb_r;
         if (ph_r != PH_ALIGN) begin
            scr_r <= scr_next(scr_r);
         end
         ts_r <= (ts_r >> 1) ^ (ts_r[0] ? TS_TAPS : 7'h00);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sha_r <= 16'h0000;
         shb_r <= 16'h0000;
         rda_r <= 7'sd0;
         rdb_r <= 7'sd0;
      end else if (frame_end & ~sync_pulse) begin
         if (ph_r == PH_ALIGN) begin
            sha_r <= seq_r[0] ? ALIGN_ODD : ALIGN_EVEN;
            shb_r <= seq_r[0] ? ALIGN_ODD : ALIGN_EVEN;
         end else begin
            sha_r <= enc_a.word;
            shb_r <= enc_b.word;
            rda_r <= enc_a.rd;
            rdb_r <= enc_b.rd;
         end
      end else begin
         sha_r <= {1'b0, sha_r[15:1]};
         shb_r <= {1'b0, shb_r[15:1]};
      end
   end

   assign lane_a = sha_r[0];
   assign lane_b = shb_r[0];

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence seq_pulse;
      sync_pulse;
   endsequence

   sequence seq_align_start;
      ph_r == PH_ALIGN && seq_r == 5'h00 && fcnt_r == 4'h0;
   endsequence

   a_sync_starts_align: assert property (@(posedge clk) disable iff (rst)
      seq_pulse |=> seq_align_start)
      else $error("sync pulse did not start alignment");

   a_align_word_value: assert property (@(posedge clk) disable iff (rst)
      frame_end && ph_r == PH_ALIGN && !sync_pulse |=>
         sha_r == (seq_r[0] ? ALIGN_EVEN : ALIGN_ODD))
      else $error("alignment word wrong");

   a_disp_bounded: assert property (@(posedge clk) disable iff (rst)
      rda_r <= DISP_MAX && rda_r >= -DISP_MAX && rdb_r <= DISP_MAX && rdb_r >= -DISP_MAX)
      else $error("running disparity out of range");

   a_trig_no_reset: assert property (@(posedge clk) disable iff (rst)
      trigger_mode_enable |=> fcnt_r == $past(fcnt_r) + 4'h1)
      else $error("trigger mode caused a timing reset");

   a_scr_reset_seed: assert property (@(posedge clk) disable iff (rst)
      seq_pulse |=> scr_r == SCR_SEED && ts_r == TS_SEED)
      else $error("scrambler or timestamp not reseeded");

   a_ready_holdoff: assert property (@(posedge clk) disable iff (rst)
      sync_pulse && rdly_r[RLEN_LSB +: 6] >= 6'h02 |=> !data_ready [*2])
      else $error("data ready not stopped after sync");

   a_sso_period: assert property (@(posedge clk) disable iff (rst)
      $rose(slow_reference_clock) |-> ##8 $fell(slow_reference_clock))
      else $error("slow reference not divided by 16");

   a_sync_out_follow: assert property (@(posedge clk) disable iff (rst)
      $changed(lvl_r) |=> chained_sync_output == $past(lvl_r))
      else $error("chained sync output lags input");

   a_prbs_after_align: assert property (@(posedge clk) disable iff (rst)
      frame_end && ph_r == PH_ALIGN && seq_r == SEQ_LAST && !sync_pulse |=> ph_r == PH_PRBS)
      else $error("no scrambler frames after alignment");
endmodule : slk_top

`default_nettype wire

// >>> bench/slk_rx_model.sv
// receiver model for one serial lane
`timescale 1ns/10ps
`default_nettype none
module slk_rx_model (
   // clock and hunt restart
   input  wire logic   clk,
   input  wire logic   arm,
   input  wire logic   lane,
   // recovered frames
   output logic        stb,
   output logic [7:0]  idx,
   output logic [15:0] sr_r,
   output logic [13:0] payload,
   output logic        err
);
   logic        lock_r;
   logic        ck_r;
   logic [3:0]  bit_r;
   logic [16:0] lfsr_r;
   logic [16:0] nxt;
   logic [15:0] dec;
   function automatic logic [16:0] step(input logic [16:0] s);
      return {s[13:0] ^ s[16:3], s[16:14]};
   endfunction : step
   // ****
   // lock on first alignment word, one frame per 16 bits
   // ****
   assign dec     = sr_r[15] ? {1'b1, ~sr_r[14:0]} : sr_r;
   assign nxt     = step(lfsr_r);
   assign payload = dec[13:0] ^ nxt[13:0];
   always_ff @(posedge clk) begin
      sr_r  <= {lane, sr_r[15:1]};
      bit_r <= bit_r + 4'h1;
      stb   <= lock_r && bit_r == 4'hF;
      if (arm) begin
         lock_r <= 1'b0;
         stb    <= 1'b0;
         err    <= 1'b0;
      end else if (!lock_r && {lane, sr_r[15:1]} == 16'h00FF) begin
         lock_r <= 1'b1;
         bit_r  <= 4'h0;
         stb    <= 1'b1;
         idx    <= 8'h00;
      end else if (stb) begin
         idx  <= idx + 8'h01;
         ck_r <= dec[14];
         if (idx > 8'd32 && dec[14] == ck_r) err <= 1'b1;
         if (idx == 8'd32) lfsr_r[13:0] <= dec[13:0];
         if (idx == 8'd33) lfsr_r <= step({dec[2:0], lfsr_r[13:0]});
         if (idx > 8'd33) lfsr_r <= nxt;
         if (idx > 8'd33 && idx < 8'd64 && payload != 14'h0) err <= 1'b1;
      end
   end
endmodule : slk_rx_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the serial link sync block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
   import slk_pkg::*;
   localparam logic [6:0] RA [9] = '{ADR_DEVICE_CONTROL, ADR_CM_TRIM_A, ADR_TERM_TRIM_A,
      ADR_CM_TRIM_B, ADR_TERM_TRIM_B, ADR_CONTROL_BIT_SEL, ADR_RESTART_DELAY,
      ADR_SYNC_EDGE_SEL, 7'h10};
   localparam logic [15:0] RV [9] = '{CTL_RESET, 16'h0010, 16'h0010, 16'h0010,
      16'h0010, 16'h0000, RDLY_RESET, 16'h0000, 16'h0000};
   localparam logic [11:0] SA [8] = '{12'h001, 12'hFFF, 12'h000, 12'h800, 12'h7FF,
      12'hA5A, 12'h123, 12'hFFE};
   logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, arm = 1'b1;
   logic [6:0]  reg_addr = 7'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_d, frm;
   logic        sample_valid = 1'b0, sat_a = 1'b0, sat_b = 1'b0, sync_trigger_input = 1'b0;
   logic [11:0] sample_a = 12'h000, sample_b = 12'h000;
   logic        sample_ready, chained_sync_output, slow_reference_clock, data_ready;
   logic        lane_a, lane_swing_reduce, bandwidth_select, aux_output_swing, stb, rxe;
   logic        lane_b, rxe_b;
   logic        sso_prev = 1'b0;
   logic [4:0]  termination_trim_a, termination_trim_b, common_mode_trim_a, common_mode_trim_b;
   logic [7:0]  idx, idx_b;
   logic [13:0] pay;
   int          err_count = 0, checked = 0, sso_cnt = 0, sso_seen = 0, lo, hi, np = 0;
   slk_top dut_u (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .sample_valid, .sample_ready, .sample_a, .sat_a, .sample_b, .sat_b,
      .sync_trigger_input, .chained_sync_output, .slow_reference_clock, .data_ready,
      .lane_a, .lane_b, .lane_swing_reduce, .bandwidth_select, .aux_output_swing,
      .termination_trim_a, .termination_trim_b, .common_mode_trim_a, .common_mode_trim_b);
   slk_rx_model rx_u (.clk, .arm, .lane(lane_a), .stb, .idx, .sr_r(frm), .payload(pay),
      .err(rxe));
   slk_rx_model rx_b (.clk, .arm, .lane(lane_b), .stb(), .idx(idx_b), .sr_r(), .payload(),
      .err(rxe_b));
   // ****
   // tasks
   // ****
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      d      = reg_rdata;
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic pulse_sync(input int n);
      lo = 0;
      hi = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk);
         sync_trigger_input = (k < n);
         lo += (data_ready === 1'b0);
         hi += (chained_sync_output === 1'b1);
      end
   endtask : pulse_sync
   task automatic conclude();
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   always #5 clk = ~clk;
   // restart the hunt once holdoff ends
   always @(posedge data_ready) if (lo != 0) begin
      @(negedge clk);
      arm = 1'b1;
      @(negedge clk);
      arm = 1'b0;
   end
   always @(negedge clk) begin
      sso_cnt++;
      if (slow_reference_clock !== sso_prev) begin
         if (sso_seen) `CHK(sso_cnt, 8)
         sso_seen = !rst;
         sso_cnt  = 0;
         sso_prev = slow_reference_clock;
      end
   end
   // leading empty normal frames are skipped
   always @(negedge clk) begin
      if (stb === 1'b1 && idx < 8'd32) `CHK(frm, idx[0] ? ALIGN_ODD : ALIGN_EVEN)
      else if (stb === 1'b1 && idx > 8'd63 && np < 9 && !(np == 0 && pay == 14'h0)) begin
         `CHK(pay, {1'b0, ^SA[np[2:0]] & (np < 8), SA[np[2:0]] & {12{np < 8}}})
         np++;
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd(RA[i], rd_d);
         `CHK(rd_d, RV[i])
      end
      `CHK({lane_swing_reduce, bandwidth_select, aux_output_swing}, 3'b110)
      for (int i = 1; i < 5; i++) begin
         wr(RA[i], 16'h001C + 16'(i));
         rd(RA[i], rd_d);
         `CHK(rd_d, (16'h001C + 16'(i)) & 16'h001F)
      end
      wr(ADR_DEVICE_CONTROL, 16'h0101);
      wr(ADR_CONTROL_BIT_SEL, 16'h0003);
      @(negedge clk);
      `CHK({lane_swing_reduce, bandwidth_select, aux_output_swing}, 3'b001)
      `CHK({common_mode_trim_a, termination_trim_a, common_mode_trim_b, termination_trim_b},
         {5'h1D, 5'h1E, 5'h1F, 5'h00})
      pulse_sync(4);
      `CHK(lo, int'(RDLY_RESET[11:RLEN_LSB]) + 1)
      `CHK(hi, 4)
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         `CHK(sample_ready, 1'b1)
         sample_valid = 1'b1;
         sample_a     = SA[i];
         sample_b     = ~SA[i];
         sat_a        = i[0];
         sat_b        = ~i[0];
      end
      @(negedge clk);
      sample_valid = 1'b0;
      `CHK(sample_ready, 1'b0)
      for (int k = 0; k < 1500 && np < 9; k++)
         @(negedge clk);
      `CHK(np, 9)
      `CHK(rxe, 1'b0)
      wr(ADR_DEVICE_CONTROL, 16'h0181);
      pulse_sync(6);
      `CHK(lo, 0)
      `CHK(hi, 6)
      `CHK(rxe, 1'b0)
      `CHK({rxe_b, idx_b}, {1'b0, idx})
      conclude();
   end
endmodule : tb_top
`default_nettype wire
